// file: rtl/ipbs_pkg.sv
// Constants shared by the interrupt priority bank six register and its source gates
package ipbs_pkg;

  // ****************************************************************
  // Bus and register geometry
  // ****************************************************************
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam logic [7:0] PRIO_CTRL_SIX_OFS = 8'h00;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int FIELD_W = 3;
  localparam int NUM_SRC = 4;
  localparam int FIELD_STRIDE = 4;
  // Source index: field lsb is index times stride
  localparam int SRC_TIMER5 = 0;
  localparam int SRC_EXT_IRQ2 = 1;
  localparam int SRC_SERIAL2_RX = 2;
  localparam int SRC_SERIAL2_TX = 3;
  localparam int TIMER5_LSB = 0;
  localparam int EXT_IRQ2_LSB = 4;
  localparam int SERIAL2_RX_LSB = 8;
  localparam int SERIAL2_TX_LSB = 12;

  // ****************************************************************
  // Field codes and reset values
  // ****************************************************************
  localparam logic [2:0] PRIO_OFF = 3'h0;
  localparam logic [2:0] PRIO_MIN = 3'h1;
  localparam logic [2:0] PRIO_MAX = 3'h7;
  localparam logic [2:0] PRIO_RESET = 3'h4;
  localparam logic [15:0] IMPL_MASK = 16'h7777;
  localparam logic [15:0] CTRL_RESET = 16'h4444;
  localparam logic [15:0] READ_IDLE = 16'h0000;

endpackage

// file: rtl/ipbs_src_gate.sv
// One interrupt source gate: blocks disabled sources and reports the request level
`timescale 1ns/1ps
module ipbs_src_gate #(
  parameter int FIELD_W = ipbs_pkg::FIELD_W
) (
  input wire logic core_clk, // System clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic srcFlag, // Event flag of the source
  input wire logic [FIELD_W-1:0] prioField, // Priority field from the register
  output logic srcReq, // Registered interrupt request
  output logic [FIELD_W-1:0] reqLevel // Registered level of the request
);

  logic srcReq_r;
  logic srcReq_nxt;
  logic [FIELD_W-1:0] reqLevel_r;
  logic [FIELD_W-1:0] reqLevel_nxt;

  // ****************************************************************
  // Request gating
  // ****************************************************************
  always_comb begin
    // Code zero disables the source outright
    srcReq_nxt = srcFlag && (prioField != ipbs_pkg::PRIO_OFF);
    // Code is the level itself, 1 lowest, 7 highest
    reqLevel_nxt = srcReq_nxt ? prioField : ipbs_pkg::PRIO_OFF;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      srcReq_r <= 1'b0;
      reqLevel_r <= ipbs_pkg::PRIO_OFF;
    end else begin
      srcReq_r <= srcReq_nxt;
      reqLevel_r <= reqLevel_nxt;
    end
  end

  assign srcReq = srcReq_r;
  assign reqLevel = reqLevel_r;

endmodule

// file: rtl/ipbs_bank.sv
// Interrupt priority control register six with per-source request gating
//
// Functional notes
// - Serial2 tx field 14-12, rx field 10-8
// - Ext irq2 field 6-4, timer5 field 2-0
// - Code 111 means level 7, highest
// - Codes map linearly, 001 is level 1
// - Code 000 disables the source, no request
// - Bits 15, 11, 7, 3 read zero
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module ipbs_bank #(
  parameter int ADDR_W = ipbs_pkg::ADDR_W,
  parameter int DATA_W = ipbs_pkg::DATA_W,
  parameter int NUM_SRC = ipbs_pkg::NUM_SRC,
  parameter int FIELD_W = ipbs_pkg::FIELD_W
) (
  input wire logic core_clk, // System clock, 40 MHz
  input wire logic rstn, // Synchronous reset, active low
  input wire logic [ADDR_W-1:0] regAddr, // Register address
  input wire logic [DATA_W-1:0] regWdata, // Write data
  input wire logic regWrite, // Write strobe
  input wire logic regRead, // Read strobe
  output logic [DATA_W-1:0] regRdata, // Read data, cycle after strobe
  input wire logic [NUM_SRC-1:0] srcFlag, // Source event flags
  output logic [NUM_SRC-1:0] srcReq, // Gated requests
  output logic [NUM_SRC-1:0][FIELD_W-1:0] srcReqLevel, // Level of each request
  output logic [FIELD_W-1:0] serial2_tx_priority, // Serial2 transmitter field
  output logic [FIELD_W-1:0] serial2_rx_priority, // Serial2 receiver field
  output logic [FIELD_W-1:0] ext_irq2_priority, // External irq2 field
  output logic [FIELD_W-1:0] timer5_priority // Timer5 field
);

  logic [DATA_W-1:0] ctrlReg_r;
  logic [DATA_W-1:0] ctrlReg_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic addrHit;
  logic [NUM_SRC-1:0][FIELD_W-1:0] prioField;

  // ****************************************************************
  // Address decode and register update
  // ****************************************************************
  assign addrHit = (regAddr == ipbs_pkg::PRIO_CTRL_SIX_OFS);

  always_comb begin
    ctrlReg_nxt = ctrlReg_r;
    rdata_nxt = ipbs_pkg::READ_IDLE;
    if (regWrite && addrHit) begin
      // Gap bits are never stored, so they cannot read back
      ctrlReg_nxt = regWdata & ipbs_pkg::IMPL_MASK;
    end
    if (regRead && addrHit) begin
      rdata_nxt = ctrlReg_r & ipbs_pkg::IMPL_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctrlReg_r <= ipbs_pkg::CTRL_RESET;
      rdata_r <= ipbs_pkg::READ_IDLE;
    end else begin
      ctrlReg_r <= ctrlReg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign regRdata = rdata_r;

  // ****************************************************************
  // Field outputs
  // ****************************************************************
  assign serial2_tx_priority = ctrlReg_r[ipbs_pkg::SERIAL2_TX_LSB +: FIELD_W];
  assign serial2_rx_priority = ctrlReg_r[ipbs_pkg::SERIAL2_RX_LSB +: FIELD_W];
  assign ext_irq2_priority = ctrlReg_r[ipbs_pkg::EXT_IRQ2_LSB +: FIELD_W];
  assign timer5_priority = ctrlReg_r[ipbs_pkg::TIMER5_LSB +: FIELD_W];

  // ****************************************************************
  // Per-source gates
  // ****************************************************************
  // Gates add one cycle; an arbiter downstream sees aligned flag and level
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
      assign prioField[gi] = ctrlReg_r[gi*ipbs_pkg::FIELD_STRIDE +: FIELD_W];

      ipbs_src_gate #(
        .FIELD_W(FIELD_W)
      ) u_gate (
        .core_clk(core_clk),
        .rstn(rstn),
        .srcFlag(srcFlag[gi]),
        .prioField(prioField[gi]),
        .srcReq(srcReq[gi]),
        .reqLevel(srcReqLevel[gi])
      );

      // ************************************************************
      // Per-source checks
      // ************************************************************
      AST_DISABLED_NO_REQ: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (prioField[gi] == ipbs_pkg::PRIO_OFF) |=> !srcReq[gi] && (srcReqLevel[gi] == ipbs_pkg::PRIO_OFF)
      ) else $error("Disabled source raised a request");

      AST_TOP_LEVEL: assert property (
        @(posedge core_clk) disable iff (!rstn)
        srcFlag[gi] && (prioField[gi] == ipbs_pkg::PRIO_MAX) |=>
          srcReq[gi] && (srcReqLevel[gi] == ipbs_pkg::PRIO_MAX)
      ) else $error("Code 111 did not give level 7");

      AST_LINEAR_LEVEL: assert property (
        @(posedge core_clk) disable iff (!rstn)
        srcFlag[gi] && (prioField[gi] != ipbs_pkg::PRIO_OFF) |=>
          srcReq[gi] && (srcReqLevel[gi] == $past(prioField[gi]))
      ) else $error("Request level differs from field code");

      AST_NO_FLAG_NO_REQ: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !srcFlag[gi] |=> !srcReq[gi]
      ) else $error("Request without source flag");

      AST_MIN_LEVEL: assert property (
        @(posedge core_clk) disable iff (!rstn)
        srcFlag[gi] && (prioField[gi] == ipbs_pkg::PRIO_MIN) |=>
          srcReq[gi] && (srcReqLevel[gi] == ipbs_pkg::PRIO_MIN)
      ) else $error("Code 001 did not give level 1");

      AST_IDLE_LEVEL_ZERO: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !srcReq[gi] |-> (srcReqLevel[gi] == ipbs_pkg::PRIO_OFF)
      ) else $error("Level shown without a request");

      AST_REQ_HAS_LEVEL: assert property (
        @(posedge core_clk) disable iff (!rstn)
        srcReq[gi] |-> (srcReqLevel[gi] != ipbs_pkg::PRIO_OFF)
      ) else $error("Request shown with level zero");
    end
  endgenerate

  // ****************************************************************
  // Register checks
  // ****************************************************************
  AST_RESET_VALUE: assert property (
    @(posedge core_clk)
    !rstn |=> (timer5_priority == ipbs_pkg::PRIO_RESET) && (ext_irq2_priority == ipbs_pkg::PRIO_RESET) &&
      (serial2_rx_priority == ipbs_pkg::PRIO_RESET) && (serial2_tx_priority == ipbs_pkg::PRIO_RESET)
  ) else $error("Fields not at level 4 after reset");

  AST_TX_RX_WRITE: assert property (
    @(posedge core_clk) disable iff (!rstn)
    regWrite && addrHit |=>
      (serial2_tx_priority == $past(regWdata[ipbs_pkg::SERIAL2_TX_LSB +: FIELD_W])) &&
      (serial2_rx_priority == $past(regWdata[ipbs_pkg::SERIAL2_RX_LSB +: FIELD_W]))
  ) else $error("Serial2 fields did not take written value");

  AST_EXT_TMR_WRITE: assert property (
    @(posedge core_clk) disable iff (!rstn)
    regWrite && addrHit |=>
      (ext_irq2_priority == $past(regWdata[ipbs_pkg::EXT_IRQ2_LSB +: FIELD_W])) &&
      (timer5_priority == $past(regWdata[ipbs_pkg::TIMER5_LSB +: FIELD_W]))
  ) else $error("Ext irq2 or timer5 field did not take written value");

  AST_GAP_BITS_ZERO: assert property (
    @(posedge core_clk) disable iff (!rstn)
    ((regRdata & ~ipbs_pkg::IMPL_MASK) == ipbs_pkg::READ_IDLE) &&
      ((ctrlReg_r & ~ipbs_pkg::IMPL_MASK) == ipbs_pkg::READ_IDLE)
  ) else $error("Unimplemented bit is set");

  AST_READ_BACK: assert property (
    @(posedge core_clk) disable iff (!rstn)
    regRead && addrHit && !regWrite ##1 regRead && addrHit |=> regRdata == $past(ctrlReg_r)
  ) else $error("Read data do not match the register");

  AST_WRITE_THEN_READ: assert property (
    @(posedge core_clk) disable iff (!rstn)
    regWrite && addrHit ##1 regRead && addrHit |=>
      regRdata == ($past(regWdata, 2) & ipbs_pkg::IMPL_MASK)
  ) else $error("Write then read did not return masked data");

  AST_MISS_HOLDS: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !(regWrite && addrHit) |=> $stable(ctrlReg_r)
  ) else $error("Register changed without a write");

  AST_IDLE_READ_ZERO: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !(regRead && addrHit) |=> regRdata == ipbs_pkg::READ_IDLE
  ) else $error("Read data outside the answer cycle");

  // ****************************************************************
  // Reset checks
  // ****************************************************************
  // Downstream arbiter must see no stale request straight after reset
  AST_RESET_CLEARS: assert property (
    @(posedge core_clk)
    !rstn |=> (srcReq == '0) && (srcReqLevel == '0) && (regRdata == ipbs_pkg::READ_IDLE)
  ) else $error("Requests or read data not cleared by reset");

  // ****************************************************************
  // Scenario coverage
  // ****************************************************************
  COV_WRITE_READ: cover property (
    @(posedge core_clk) disable iff (!rstn)
    regWrite && addrHit ##1 regRead && addrHit
  );

  COV_DISABLE_SOURCE: cover property (
    @(posedge core_clk) disable iff (!rstn)
    srcFlag[ipbs_pkg::SRC_TIMER5] && (timer5_priority == ipbs_pkg::PRIO_OFF)
  );

  COV_MAX_REQ: cover property (
    @(posedge core_clk) disable iff (!rstn)
    srcReq[ipbs_pkg::SRC_SERIAL2_TX] && (srcReqLevel[ipbs_pkg::SRC_SERIAL2_TX] == ipbs_pkg::PRIO_MAX)
  );

  COV_MIN_REQ: cover property (
    @(posedge core_clk) disable iff (!rstn)
    srcReq[ipbs_pkg::SRC_EXT_IRQ2] && (srcReqLevel[ipbs_pkg::SRC_EXT_IRQ2] == ipbs_pkg::PRIO_MIN)
  );

  COV_RESET_LEVEL_REQ: cover property (
    @(posedge core_clk) disable iff (!rstn)
    srcReq[ipbs_pkg::SRC_SERIAL2_RX] && (srcReqLevel[ipbs_pkg::SRC_SERIAL2_RX] == ipbs_pkg::PRIO_RESET)
  );

endmodule

// file: verif/tb.sv
// Self-checking bench for the interrupt priority bank six register and its source gates
`timescale 1ns/1ps
module tb;
  // ****************************************************************
  // Signals and bench state
  // ****************************************************************
  typedef struct packed {
    logic [15:0] rd;
    logic [3:0] req;
    logic [11:0] lvl;
    logic [15:0] fld;
  } ipbs_note_t;

  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWdata = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [15:0] regRdata;
  logic [3:0] srcFlag = 4'h0;
  logic [3:0] srcReq;
  logic [3:0][2:0] srcReqLevel;
  logic [2:0] txPrio, rxPrio, extPrio, tmrPrio;
  logic [15:0] regM;
  logic due = 1'b0;
  logic [31:0] rv;
  ipbs_note_t noteQ[$];
  ipbs_note_t mn;
  integer seed = 32'h76ce71f9;
  int errorCnt = 0;
  int nTests = 0;

  ipbs_bank DUT (
    .core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .srcFlag(srcFlag),
    .srcReq(srcReq), .srcReqLevel(srcReqLevel), .serial2_tx_priority(txPrio),
    .serial2_rx_priority(rxPrio), .ext_irq2_priority(extPrio), .timer5_priority(tmrPrio)
  );

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  // ****************************************************************
  // Driver: one bus cycle plus flags, noting what must follow
  // ****************************************************************
  task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d,
                     input logic [3:0] f);
    ipbs_note_t n;
    logic [2:0] fv;
    @(posedge core_clk);
    regWrite <= w;
    regRead <= r;
    regAddr <= a;
    regWdata <= d;
    srcFlag <= f;
    n.rd = (r && a == 8'h00) ? regM : 16'h0000;
    // Gate sees the field as it stood before a write in the same cycle
    for (int i = 0; i < 4; i++) begin
      fv = regM[4*i +: 3];
      n.req[i] = f[i] && fv != 3'h0;
      n.lvl[3*i +: 3] = n.req[i] ? fv : 3'h0;
    end
    if (w && a == 8'h00) begin
      regM = d & 16'h7777;
    end
    n.fld = regM;
    noteQ.push_back(n);
  endtask

  task automatic chkRdata(input logic [15:0] e, input logic [15:0] g);
    nTests++;
    if (g !== e) begin
      errorCnt++;
      $display("[ERR] regRdata expected %h got %h", e, g);
    end
  endtask

  task automatic chkReq(input logic [3:0] e, input logic [3:0] g);
    nTests++;
    if (g !== e) begin
      errorCnt++;
      $display("[ERR] srcReq expected %h got %h", e, g);
    end
  endtask

  task automatic chkLevel(input logic [11:0] e, input logic [11:0] g);
    nTests++;
    if (g !== e) begin
      errorCnt++;
      $display("[ERR] srcReqLevel expected %h got %h", e, g);
    end
  endtask

  task automatic chkFields(input logic [15:0] e, input logic [15:0] g);
    nTests++;
    if (g !== e) begin
      errorCnt++;
      $display("[ERR] fields expected %h got %h", e, g);
    end
  endtask

  task automatic endOfTest();
    if (errorCnt == 0 && nTests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Monitor: outputs are settled by the falling edge
  // ****************************************************************
  always @(negedge core_clk) begin
    if (due) begin
      mn = noteQ.pop_front();
      chkRdata(mn.rd, regRdata);
      chkReq(mn.req, srcReq);
      chkLevel(mn.lvl, srcReqLevel);
      chkFields(mn.fld, {1'b0, txPrio, 1'b0, rxPrio, 1'b0, extPrio, 1'b0, tmrPrio});
    end
    due = noteQ.size() > 0;
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    regM = 16'h4444;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    cyc(1'b0, 1'b1, 8'h00, 16'h0000, 4'hf);
    cyc(1'b1, 1'b0, 8'h00, 16'hffff, 4'hf);
    cyc(1'b0, 1'b1, 8'h00, 16'h0000, 4'hf);
    // Every code on every field, flags held so requests follow the code
    for (int c = 0; c < 8; c++) begin
      cyc(1'b1, 1'b0, 8'h00, {4{1'b1, c[2:0]}}, 4'hf);
      cyc(1'b0, 1'b1, 8'h00, 16'h0000, 4'hf);
    end
    // One field live at a time shows a swapped position
    for (int i = 0; i < 4; i++) begin
      cyc(1'b1, 1'b0, 8'h00, 16'h0005 << (4*i), 4'hf);
      cyc(1'b0, 1'b1, 8'h00, 16'h0000, 4'hf);
    end
    // Unmapped places change nothing and read zero
    cyc(1'b1, 1'b0, 8'h01, 16'h7777, 4'h0);
    cyc(1'b0, 1'b1, 8'h80, 16'h0000, 4'h0);
    cyc(1'b0, 1'b1, 8'h00, 16'h0000, 4'h0);
    repeat (300) begin
      rv = $random(seed);
      cyc(rv[0], rv[1] & ~rv[0], (rv[3:2] != 2'b00) ? 8'h00 : rv[11:4], rv[31:16], rv[15:12]);
    end
    cyc(1'b0, 1'b0, 8'h00, 16'h0000, 4'h0);
    repeat (3) @(posedge core_clk);
    endOfTest();
  end

  // Hang guard, well beyond the few hundred cycles of stimulus
  initial begin
    #(25 * 5000);
    errorCnt++;
    endOfTest();
  end
endmodule
